/* src/dac_update_config_regs.sv */
// Monitor/update control and DAC range/load configuration registers
// How it works
// [RL1] Both configuration registers come out of reset as all zeros.
// [RL2] Control bit 0 picks slow or fast converter clock; fast disables diode filters.
// [RL3] Control bit 1 picks 8 or 10 bit thermal output; 8-bit parts write zero.
// [RL4] Control bit 3 picks load pin or register-driven DAC updates.
// [RL5] Control bit 5 makes DAC A follow internal temperature.
// [RL6] Control bit 6 makes DAC B follow external temperature.
// [RL7] Host writes zero to reserved control bits 2, 4 and 7.
// [RL8] Config bits 0 to 3 pick single or double reference range per DAC.
// [RL9] Load mode 00: upper-byte write loads only that DAC.
// [RL10] Load mode 01: upper byte of B loads A and B; of D loads C and D.
// [RL11] Load mode 10: upper byte of D loads all four DACs.
// [RL12] Load mode 11: data writes never load; the load register does.
// [RL13] Config bits 6 and 7 bypass the reference buffer per DAC pair.
// [RL14] Load mode acts only while register-driven updates are selected.
// [RL15] Load register bits 0 to 3 load one DAC each and read as zero.
// [RL16] Upper and lower bytes join into the full converted code.
// [RL17] Output code copies input bytes only on a load for that DAC.
module dac_update_config_regs
    import dac_cfg_pkg::*;
#(
    parameter int unsigned DAC_W = 12
)(
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [ADDR_W-1:0]             reg_addr,
    input  wire logic [DATA_W-1:0]             reg_wdata,
    output logic      [DATA_W-1:0]             reg_rdata,
    input  wire logic                          dac_load_strobe_n,
    input  wire logic [TEMP_W-1:0]             int_temp_code,
    input  wire logic [TEMP_W-1:0]             ext_temp_code,
    output logic      [NUM_DAC-1:0][DAC_W-1:0] dac_code,
    output logic      [NUM_DAC-1:0]            dac_range_x2,
    output logic                               vref_bypass_ab,
    output logic                               vref_bypass_cd,
    output logic                               vref_internal,
    output logic                               adc_fast_clk,
    output logic                               diode_filter_off,
    output logic                               thermal_hi_res
);
    typedef struct packed {
        logic [DATA_W-1:0] ctrl3;
        logic [DATA_W-1:0] dcfg;
        logic              vref_int;
        logic [DATA_W-1:0] rdata;
    } regs_t;

    regs_t r_q;
    regs_t r_d;

    dac_store_if sif ();

    logic             wr_ctrl3;
    logic             wr_dcfg;
    logic             wr_ldcfg;
    logic             dac_hit;
    logic             msb_wr;
    logic [IDX_W-1:0] wr_idx;
    load_mode_t       mode;
    logic             sw_update;
    logic [3:0]       load;

    // Address decode; DAC bytes sit in pairs, lower byte first
    assign dac_hit  = (reg_addr & DAC_ADDR_MASK) == ADDR_DAC_BASE;
    assign wr_idx   = reg_addr[IDX_W:1];
    assign wr_ctrl3 = reg_wr && reg_addr == ADDR_CTRL3;
    assign wr_dcfg  = reg_wr && reg_addr == ADDR_DCFG;
    assign wr_ldcfg = reg_wr && reg_addr == ADDR_LDCFG;
    assign msb_wr   = reg_wr && dac_hit && reg_addr[0];

    assign mode      = load_mode_t'(r_q.dcfg[DCFG_MODE_LO +: 2]);
    assign sw_update = r_q.ctrl3[C3_SWLOAD];

    // Load command generation; the pin is a level, held low it keeps loading
    always_comb
    begin
        load = LOAD_NONE;
        if (!sw_update)
        begin
            load = dac_load_strobe_n ? LOAD_NONE : LOAD_ALL; // RL4 RL14
        end
        else
        begin
            case (mode)
                LMODE_SINGLE:
                    if (msb_wr)
                        load = 4'(1) << wr_idx; // RL9
                LMODE_PAIR:
                    if (msb_wr && wr_idx == DAC_B)
                        load = LOAD_AB; // RL10
                    else if (msb_wr && wr_idx == DAC_D)
                        load = LOAD_CD; // RL10
                LMODE_ALL:
                    if (msb_wr && wr_idx == DAC_D)
                        load = LOAD_ALL; // RL11
                LMODE_REG:
                    if (wr_ldcfg)
                        load = reg_wdata[LD_CMD_LO +: NUM_DAC]; // RL12 RL15
                default:
                    load = LOAD_NONE;
            endcase
        end
    end

    // Register writes and registered read data
    always_comb
    begin
        r_d = r_q;
        if (wr_ctrl3)
            r_d.ctrl3 = reg_wdata;
        if (wr_dcfg)
            r_d.dcfg = reg_wdata;
        if (wr_ldcfg)
            r_d.vref_int = reg_wdata[LD_VREF_INT];
        if (reg_rd)
        begin
            if (reg_addr == ADDR_CTRL3)
                r_d.rdata = r_q.ctrl3;
            else if (reg_addr == ADDR_DCFG)
                r_d.rdata = r_q.dcfg;
            else if (reg_addr == ADDR_LDCFG)
                r_d.rdata = BYTE_ZERO | (DATA_W'(r_q.vref_int) << LD_VREF_INT); // RL15
            else if (dac_hit && reg_addr[0])
                r_d.rdata = sif.in_msb[wr_idx];
            else if (dac_hit)
                r_d.rdata = sif.in_lsb[wr_idx];
            else
                r_d.rdata = BYTE_ZERO;
        end
    end

    // Power-up clears every control bit
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_q.ctrl3    <= CTRL3_RST; // RL1
            r_q.dcfg     <= DCFG_RST; // RL1
            r_q.vref_int <= 1'b0;
            r_q.rdata    <= BYTE_ZERO;
        end
        else
            r_q <= r_d;
    end

    // Store port; reserved control bits are kept but steer nothing
    assign sif.wr_en   = reg_wr && dac_hit;
    assign sif.wr_idx  = wr_idx;
    assign sif.wr_msb  = reg_addr[0];
    assign sif.wr_data = reg_wdata;
    assign sif.load    = load;
    assign sif.track_a = r_q.ctrl3[C3_TRACK_A]; // RL5
    assign sif.track_b = r_q.ctrl3[C3_TRACK_B]; // RL6
    assign sif.hi_res  = r_q.ctrl3[C3_HIRES]; // RL3

    dac_code_store #(
        .DAC_W (DAC_W)
    ) u_store (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .sif           (sif),
        .int_temp_code (int_temp_code),
        .ext_temp_code (ext_temp_code),
        .dac_code      (dac_code)
    );

    // Configuration outputs straight from the flops
    assign reg_rdata        = r_q.rdata;
    assign adc_fast_clk     = r_q.ctrl3[C3_FAST]; // RL2
    assign diode_filter_off = r_q.ctrl3[C3_FAST]; // RL2
    assign thermal_hi_res   = r_q.ctrl3[C3_HIRES]; // RL3
    assign dac_range_x2     = r_q.dcfg[DCFG_RANGE_LO +: NUM_DAC]; // RL8
    assign vref_bypass_ab   = r_q.dcfg[DCFG_BYP_AB]; // RL13
    assign vref_bypass_cd   = r_q.dcfg[DCFG_BYP_CD]; // RL13
    assign vref_internal    = r_q.vref_int;

    property p_reset_zero;
        @(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> r_q.ctrl3 == CTRL3_RST && r_q.dcfg == DCFG_RST;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("Config not zero after reset"); // RL1

    property p_fast_clk;
        @(posedge clk) disable iff (sys_rst)
        wr_ctrl3 |=> adc_fast_clk == $past(reg_wdata[C3_FAST])
            && diode_filter_off == adc_fast_clk;
    endproperty
    a_fast_clk: assert property (p_fast_clk) else $error("Converter clock select wrong"); // RL2

    property p_pin_load;
        @(posedge clk) disable iff (sys_rst)
        !sw_update |-> $countones(load) == (dac_load_strobe_n ? 0 : NUM_DAC);
    endproperty
    a_pin_load: assert property (p_pin_load) else $error("Pin mode load wrong"); // RL14

    property p_single;
        @(posedge clk) disable iff (sys_rst)
        sw_update && mode == LMODE_SINGLE && msb_wr |-> load[wr_idx] && $onehot(load);
    endproperty
    a_single: assert property (p_single) else $error("Single load wrong"); // RL9

    property p_pair;
        @(posedge clk) disable iff (sys_rst)
        sw_update && mode == LMODE_PAIR && msb_wr
            |-> load == (wr_idx == DAC_B ? LOAD_AB : wr_idx == DAC_D ? LOAD_CD : LOAD_NONE);
    endproperty
    a_pair: assert property (p_pair) else $error("Pair load wrong"); // RL10

    property p_all;
        @(posedge clk) disable iff (sys_rst)
        sw_update && mode == LMODE_ALL
            |-> load == (msb_wr && wr_idx == DAC_D ? LOAD_ALL : LOAD_NONE);
    endproperty
    a_all: assert property (p_all) else $error("All-DAC load wrong"); // RL11

    property p_reg_mode;
        @(posedge clk) disable iff (sys_rst)
        sw_update && mode == LMODE_REG && !wr_ldcfg |-> load == LOAD_NONE;
    endproperty
    a_reg_mode: assert property (p_reg_mode) else $error("Data write loaded in mode 11"); // RL12

    property p_ld_read;
        @(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr == ADDR_LDCFG |=> reg_rdata[LD_CMD_LO +: NUM_DAC] == LOAD_NONE;
    endproperty
    a_ld_read: assert property (p_ld_read) else $error("Load bits read nonzero"); // RL15

    property p_range;
        @(posedge clk) disable iff (sys_rst)
        wr_dcfg |=> dac_range_x2 == $past(reg_wdata[DCFG_RANGE_LO +: NUM_DAC])
            && vref_bypass_ab == $past(reg_wdata[DCFG_BYP_AB])
            && vref_bypass_cd == $past(reg_wdata[DCFG_BYP_CD]);
    endproperty
    a_range: assert property (p_range) else $error("Range or bypass not updated"); // RL8 RL13
endmodule

/* inc/dac_cfg_pkg.sv */
// Constants and types shared by the DAC update configuration block
package dac_cfg_pkg;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 8;
    localparam int unsigned NUM_DAC = 4;
    localparam int unsigned TEMP_W  = 10;
    localparam int unsigned IDX_W   = 2;

    // Register map
    localparam logic [7:0] ADDR_DAC_BASE = 8'h10;
    localparam logic [7:0] DAC_ADDR_MASK = 8'hf8;
    localparam logic [7:0] ADDR_CTRL3    = 8'h1a;
    localparam logic [7:0] ADDR_DCFG     = 8'h1b;
    localparam logic [7:0] ADDR_LDCFG    = 8'h1c;

    // Power-up values
    localparam logic [7:0] CTRL3_RST = 8'h00;
    localparam logic [7:0] DCFG_RST  = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Monitor and update control fields
    localparam int unsigned C3_FAST    = 0;
    localparam int unsigned C3_HIRES   = 1;
    localparam int unsigned C3_SWLOAD  = 3;
    localparam int unsigned C3_TRACK_A = 5;
    localparam int unsigned C3_TRACK_B = 6;

    // Range and load configuration fields
    localparam int unsigned DCFG_RANGE_LO = 0;
    localparam int unsigned DCFG_MODE_LO  = 4;
    localparam int unsigned DCFG_BYP_AB   = 6;
    localparam int unsigned DCFG_BYP_CD   = 7;

    // Software load register fields
    localparam int unsigned LD_CMD_LO   = 0;
    localparam int unsigned LD_VREF_INT = 4;

    localparam logic [IDX_W-1:0] DAC_B = 2'h1;
    localparam logic [IDX_W-1:0] DAC_D = 2'h3;

    localparam logic [3:0] LOAD_NONE = 4'h0;
    localparam logic [3:0] LOAD_ALL  = 4'hf;
    localparam logic [3:0] LOAD_AB   = 4'h3;
    localparam logic [3:0] LOAD_CD   = 4'hc;

    typedef enum logic [1:0] {
        LMODE_SINGLE = 2'b00,
        LMODE_PAIR   = 2'b01,
        LMODE_ALL    = 2'b10,
        LMODE_REG    = 2'b11
    } load_mode_t;
endpackage

/* inc/dac_store_if.sv */
// Carrier between the configuration logic and the DAC code store
interface dac_store_if;
    import dac_cfg_pkg::*;
    logic                  wr_en;
    logic [IDX_W-1:0]      wr_idx;
    logic                  wr_msb;
    logic [DATA_W-1:0]     wr_data;
    logic [NUM_DAC-1:0]    load;
    logic                  track_a;
    logic                  track_b;
    logic                  hi_res;
    logic [NUM_DAC-1:0][DATA_W-1:0] in_msb;
    logic [NUM_DAC-1:0][DATA_W-1:0] in_lsb;

    modport ctrl  (output wr_en, wr_idx, wr_msb, wr_data, load, track_a, track_b, hi_res,
                   input in_msb, in_lsb);
    modport store (input wr_en, wr_idx, wr_msb, wr_data, load, track_a, track_b, hi_res,
                   output in_msb, in_lsb);
endinterface

/* src/dac_code_store.sv */
// Double-buffered DAC code store: input bytes and output codes
module dac_code_store
    import dac_cfg_pkg::*;
#(
    parameter int unsigned DAC_W = 12
)(
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    dac_store_if.store                         sif,
    input  wire logic [TEMP_W-1:0]             int_temp_code,
    input  wire logic [TEMP_W-1:0]             ext_temp_code,
    output logic      [NUM_DAC-1:0][DAC_W-1:0] dac_code
);
    typedef struct packed {
        logic [NUM_DAC-1:0][DATA_W-1:0] msb;
        logic [NUM_DAC-1:0][DATA_W-1:0] lsb;
        logic [NUM_DAC-1:0][DAC_W-1:0]  out;
    } store_t;

    store_t s_q;
    store_t s_d;

    // Upper byte on top, the top bits of the lower byte below it
    function automatic logic [DAC_W-1:0] combine(input logic [7:0] m, input logic [7:0] l);
        combine = {m, l[DATA_W-1 -: DAC_W-DATA_W]};
    endfunction

    // Temperature scaled to full DAC width; low resolution drops two bits
    function automatic logic [DAC_W-1:0] therm(input logic [TEMP_W-1:0] t, input logic hi);
        therm = hi ? (DAC_W'(t) << (DAC_W - TEMP_W))
                   : (DAC_W'(t[TEMP_W-1 -: DATA_W]) << (DAC_W - DATA_W));
    endfunction

    // Write lands first so a load in the same cycle takes the new byte
    always_comb
    begin
        s_d = s_q;
        if (sif.wr_en)
        begin
            if (sif.wr_msb)
                s_d.msb[sif.wr_idx] = sif.wr_data;
            else
                s_d.lsb[sif.wr_idx] = sif.wr_data;
        end
        for (int i = 0; i < NUM_DAC; i++)
        begin
            if (sif.load[i])
                s_d.out[i] = combine(s_d.msb[i], s_d.lsb[i]); // RL16 RL17
        end
        if (sif.track_a)
            s_d.out[0] = therm(int_temp_code, sif.hi_res); // RL5
        if (sif.track_b)
            s_d.out[1] = therm(ext_temp_code, sif.hi_res); // RL6
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign sif.in_msb = s_q.msb;
    assign sif.in_lsb = s_q.lsb;
    assign dac_code   = s_q.out;

    property p_track_a;
        @(posedge clk) disable iff (sys_rst)
        sif.track_a |=> dac_code[0] == therm($past(int_temp_code), $past(sif.hi_res));
    endproperty
    a_track_a: assert property (p_track_a) else $error("DAC A not following temperature"); // RL5

    property p_track_b;
        @(posedge clk) disable iff (sys_rst)
        sif.track_b |=> dac_code[1] == therm($past(ext_temp_code), $past(sif.hi_res));
    endproperty
    a_track_b: assert property (p_track_b) else $error("DAC B not following temperature"); // RL6

    for (genvar g = 0; g < NUM_DAC; g++)
    begin : g_chk
        property p_hold;
            @(posedge clk) disable iff (sys_rst)
            !sif.load[g] && !(g == 0 && sif.track_a) && !(g == 1 && sif.track_b)
                |=> $stable(dac_code[g]);
        endproperty
        a_hold: assert property (p_hold) else $error("DAC output moved without load"); // RL17

        property p_load;
            @(posedge clk) disable iff (sys_rst)
            sif.load[g] && !(g == 0 && sif.track_a) && !(g == 1 && sif.track_b)
                |=> dac_code[g] == combine(s_q.msb[g], s_q.lsb[g]);
        endproperty
        a_load: assert property (p_load) else $error("DAC output not the joined code"); // RL16
    end
endmodule

/* verif/dac_host_model.sv */
// Host controller model driving the parallel register port
module dac_host_model
    import dac_cfg_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] reg_rdata,
    output logic                   reg_wr,
    output logic                   reg_rd,
    output logic [ADDR_W-1:0]      reg_addr,
    output logic [DATA_W-1:0]      reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus from time zero so nothing is taken during reset
    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // Strobe stays up after the edge so writes can run back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_rd    = 1'b0;
        reg_wr    = 1'b1;
        reg_addr  = a;
        // One assignment per edge; reserved bits go out as zero
        reg_wdata = (a == ADDR_CTRL3) ? (d & 8'h6b)
                  : (a == ADDR_LDCFG) ? (d & 8'h1f) : d;
    endtask

    task automatic idle();
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask

    // Read data lands on the edge that takes the strobe; sampled at the next falling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_wr   = 1'b0;
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        d      = reg_rdata;
    endtask
endmodule

/* verif/dac_update_config_regs_tb_top.sv */
// Self-checking bench for the DAC update configuration registers
module dac_update_config_regs_tb_top;
    import dac_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned DW = 12;

    logic                       clk;
    logic                       sys_rst;
    logic                       reg_wr;
    logic                       reg_rd;
    logic [ADDR_W-1:0]          reg_addr;
    logic [DATA_W-1:0]          reg_wdata;
    logic [DATA_W-1:0]          reg_rdata;
    logic                       dac_load_strobe_n;
    logic [TEMP_W-1:0]          int_temp_code;
    logic [TEMP_W-1:0]          ext_temp_code;
    logic [NUM_DAC-1:0][DW-1:0] dac_code;
    logic [NUM_DAC-1:0]         dac_range_x2;
    logic                       vref_bypass_ab;
    logic                       vref_bypass_cd;
    logic                       vref_internal;
    logic                       adc_fast_clk;
    logic                       diode_filter_off;
    logic                       thermal_hi_res;
    int                         fail_count;
    int                         checked;
    int                         seed;
    logic [7:0]                 msb[4];
    logic [7:0]                 lsb[4];
    logic [DW-1:0]              exp_code[4];
    logic [7:0]                 c;
    logic [7:0]                 g;
    logic [7:0]                 d;

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    dac_update_config_regs #(.DAC_W(DW)) DUT (
        .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .dac_load_strobe_n(dac_load_strobe_n), .int_temp_code(int_temp_code),
        .ext_temp_code(ext_temp_code), .dac_code(dac_code), .dac_range_x2(dac_range_x2),
        .vref_bypass_ab(vref_bypass_ab), .vref_bypass_cd(vref_bypass_cd),
        .vref_internal(vref_internal), .adc_fast_clk(adc_fast_clk),
        .diode_filter_off(diode_filter_off), .thermal_hi_res(thermal_hi_res)
    );

    dac_host_model host (
        .clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata)
    );

    // Upper byte on top, lower byte trimmed to the converter width
    function automatic logic [DW-1:0] join_code(input logic [7:0] m, input logic [7:0] l);
        logic [15:0] w;
        w = {m, l};
        return DW'(w >> (16 - DW));
    endfunction

    function automatic logic [3:0] load_mask(input logic [1:0] mode, input int x);
        case (mode)
            2'b00: return 4'h1 << x;
            2'b01: return (x == 1) ? 4'h3 : ((x == 3) ? 4'hc : 4'h0);
            2'b10: return (x == 3) ? 4'hf : 4'h0;
            default: return 4'h0;
        endcase
    endfunction

    function automatic logic [DW-1:0] track(input logic [9:0] t, input logic hi);
        logic [DW-1:0] v;
        v = DW'(t);
        return hi ? (v << (DW - 10)) : ((v >> 2) << (DW - 8));
    endfunction

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, e, s);
        end
    endtask

    task automatic apply(input logic [3:0] m);
        for (int i = 0; i < 4; i++)
            if (m[i])
                exp_code[i] = join_code(msb[i], lsb[i]);
    endtask

    task automatic chk_codes();
        for (int i = 0; i < 4; i++)
            chk("dac_code", exp_code[i], dac_code[i]);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog: the whole run needs only a few hundred cycles
    initial
    begin
        #(20000 * 40);
        fail_count++;
        $display("[FAIL] watchdog expected done seen hang");
        results();
    end

    initial
    begin
        seed = 32'hf86a;
        fail_count = 0;
        checked = 0;
        sys_rst = 1'b1;
        dac_load_strobe_n = 1'b1;
        int_temp_code = 10'h000;
        ext_temp_code = 10'h000;
        for (int i = 0; i < 4; i++)
        begin
            msb[i] = 8'h00;
            lsb[i] = 8'h00;
            exp_code[i] = '0;
        end
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        // Power-up contents, outputs and an unmapped read
        host.rd(ADDR_CTRL3, d);
        chk("ctrl3", 8'h00, d);
        host.rd(ADDR_DCFG, d);
        chk("dcfg", 8'h00, d);
        host.rd(8'h30, d);
        chk("unmapped", 8'h00, d);
        chk("cfg_out", 8'h00, {dac_range_x2, vref_bypass_ab, vref_bypass_cd, adc_fast_clk,
            thermal_hi_res});
        chk_codes();
        $display("test reset done");
        // Random settings, last pass with every bit offered as one
        for (int n = 0; n < 16; n++)
        begin
            c = (n == 15) ? 8'hff : 8'($random(seed));
            g = (n == 15) ? 8'hff : 8'($random(seed));
            host.wr(ADDR_CTRL3, c);
            host.wr(ADDR_DCFG, g);
            host.idle();
            chk("adc_fast_clk", c[0], adc_fast_clk);
            chk("diode_filter_off", c[0], diode_filter_off);
            chk("thermal_hi_res", c[1], thermal_hi_res);
            chk("dac_range_x2", g[3:0], dac_range_x2);
            chk("vref_bypass", g[7:6], {vref_bypass_cd, vref_bypass_ab});
            host.rd(ADDR_CTRL3, d);
            chk("ctrl3_rd", c & 8'h6b, d);
            host.rd(ADDR_DCFG, d);
            chk("dcfg_rd", g, d);
        end
        $display("test config done");
        // Every load mode under register control, then the load register
        host.wr(ADDR_CTRL3, 8'h08);
        for (int m = 0; m < 4; m++)
        begin
            host.wr(ADDR_DCFG, {2'b00, 2'(m), 4'h0});
            for (int x = 0; x < 4; x++)
            begin
                lsb[x] = 8'($random(seed));
                msb[x] = 8'($random(seed));
                host.wr(ADDR_DAC_BASE + 8'(2 * x), lsb[x]);
                host.wr(ADDR_DAC_BASE + 8'(2 * x + 1), msb[x]);
                host.idle();
                apply(load_mask(2'(m), x));
                chk_codes();
            end
            g = 8'($random(seed));
            host.wr(ADDR_LDCFG, g);
            host.idle();
            if (m == 3)
                apply(g[3:0]);
            chk_codes();
            chk("vref_internal", g[4], vref_internal);
            host.rd(ADDR_LDCFG, d);
            chk("ldcfg_rd", {3'b000, g[4], 4'h0}, d);
        end
        $display("test load modes done");
        // Pin governs only while the update-source bit is zero
        host.wr(ADDR_CTRL3, 8'h00);
        host.wr(ADDR_DCFG, 8'h00);
        lsb[2] = 8'($random(seed));
        msb[2] = 8'($random(seed));
        host.wr(ADDR_DAC_BASE + 8'h4, lsb[2]);
        host.wr(ADDR_DAC_BASE + 8'h5, msb[2]);
        host.idle();
        chk_codes();
        dac_load_strobe_n = 1'b0;
        @(negedge clk);
        dac_load_strobe_n = 1'b1;
        apply(4'hf);
        chk_codes();
        host.wr(ADDR_CTRL3, 8'h08);
        host.wr(ADDR_DCFG, 8'h30);
        lsb[0] = 8'($random(seed));
        msb[0] = 8'($random(seed));
        host.wr(ADDR_DAC_BASE, lsb[0]);
        host.wr(ADDR_DAC_BASE + 8'h1, msb[0]);
        host.idle();
        dac_load_strobe_n = 1'b0;
        repeat (2) @(negedge clk);
        dac_load_strobe_n = 1'b1;
        chk_codes();
        $display("test pin done");
        // Temperature tracking at both resolutions
        for (int h = 0; h < 2; h++)
        begin
            int_temp_code = 10'($random(seed));
            ext_temp_code = 10'($random(seed));
            host.wr(ADDR_CTRL3, 8'h68 | 8'(h << 1));
            host.idle();
            repeat (2) @(negedge clk);
            chk("track_a", track(int_temp_code, h[0]), dac_code[0]);
            chk("track_b", track(ext_temp_code, h[0]), dac_code[1]);
        end
        $display("test tracking done");
        results();
    end
endmodule
